/* verilog/sos_regs.svh */
// Register map, field positions, reset values and timing of the selector
// How it works
// - Code 7 warns ten seconds before trip
// - Codes 8/9 on when count equals threshold
// - Code 10 on when length exceeds target
// - Code 11 gives 250 ms cycle pulse
// - Codes 12/40 compare run times to thresholds
// - Code 13 on at frequency limit clamp
// - Code 14 on at torque limit stall
// - Code 15 on when ready, no fault
// - Code 16 on when input one exceeds two
// - Code 17 on at upper frequency limit
// - Codes 18/37 lower limit, differ when stopped
// - Code 19 on during undervoltage
// - Code 20 follows communication commanded state
// - Code 23 on at zero frequency, stopped
// - Code 24 on past power-on threshold
// - Code 30 on when timing reached
// - Code 31 on outside input one window
// - Code 32 on when load is zero
// - Code 33 on while running reverse
// - Code 35 on at module temperature
// - Code 38 alarm on fault while running
// - Code 39 on at motor overheat threshold
// - Code 0 keeps terminal inactive
// - Code 1 on while running
// - Polarity bit inverts the final output
// - Delay zero to 3600 s, 0.1 s steps
`ifndef SOS_REGS_SVH
`define SOS_REGS_SVH

// Byte offsets on the APB bus
`define SOS_OFS_CTRL 8'h00
`define SOS_OFS_DELAY 8'h04
`define SOS_OFS_CNT_SET 8'h08
`define SOS_OFS_CNT_DES 8'h0C
`define SOS_OFS_LEN 8'h10
`define SOS_OFS_ACC_RUN 8'h14
`define SOS_OFS_CUR_RUN 8'h18
`define SOS_OFS_PWR_ON 8'h1C
`define SOS_OFS_TIMING 8'h20
`define SOS_OFS_AI_WIN 8'h24
`define SOS_OFS_MOD_TEMP 8'h28
`define SOS_OFS_MOT_TEMP 8'h2C
`define SOS_OFS_COMM 8'h30
`define SOS_OFS_STATUS 8'h34

// Control register fields
`define SOS_CTRL_FUNC_LSB 0
`define SOS_CTRL_FUNC_MSB 5
`define SOS_CTRL_POL_BIT 8
`define SOS_CTRL_TIMER_EN_BIT 9

// Reset values
`define SOS_RST_CTRL 32'h0000_0000
`define SOS_RST_DELAY 16'h0000
`define SOS_RST_THRESH 16'h0000
`define SOS_RST_AI_WIN 32'h0FFF_0000

// Limits
`define SOS_DELAY_MAX_TENTHS 16'h8CA0
`define SOS_PREWARN_TENTHS 16'h0064

// Timing
`define SOS_CLK_HZ 125000000
`define SOS_STEP_MS 100
`define SOS_PULSE_MS 250
`define SOS_STEP_CYCLES (`SOS_CLK_HZ / 1000 * `SOS_STEP_MS)
`define SOS_PULSE_CYCLES (`SOS_CLK_HZ / 1000 * `SOS_PULSE_MS)

`endif

/* verilog/sos_pkg.sv */
// Types shared by the status output selector
package sos_pkg;

  // Function codes of the terminal
  typedef enum logic [5:0] {
    SOS_F_NONE = 6'h00, SOS_F_RUN = 6'h01, SOS_F_OVL_WARN = 6'h07,
    SOS_F_CNT_SET = 6'h08, SOS_F_CNT_DES = 6'h09, SOS_F_LEN = 6'h0A,
    SOS_F_PLC = 6'h0B, SOS_F_ACC_RUN = 6'h0C, SOS_F_FLIM = 6'h0D,
    SOS_F_TLIM = 6'h0E, SOS_F_READY = 6'h0F, SOS_F_AI_GT = 6'h10,
    SOS_F_UPPER = 6'h11, SOS_F_LOWER = 6'h12, SOS_F_UVOLT = 6'h13,
    SOS_F_COMM = 6'h14, SOS_F_ZERO2 = 6'h17, SOS_F_PWR_ON = 6'h18,
    SOS_F_TIMING = 6'h1E, SOS_F_AI_WIN = 6'h1F, SOS_F_LOAD0 = 6'h20,
    SOS_F_REV = 6'h21, SOS_F_MOD_T = 6'h23, SOS_F_LOWER2 = 6'h25,
    SOS_F_ALARM = 6'h26, SOS_F_MOT_T = 6'h27, SOS_F_CUR_RUN = 6'h28
  } sos_func_t;

  // Output delay engine states
  typedef enum logic [0:0] {
    SOS_DLY_IDLE = 1'b0,
    SOS_DLY_WAIT = 1'b1
  } sos_dly_state_t;

endpackage

/* verilog/sos_top.sv */
// Status output selector with APB register slave and output delay
//
// Added by the designer: register access over APB and the register addresses.
`include "sos_regs.svh"

module sos_top
  import sos_pkg::*;
#(
  // Cycles per 0.1 s delay step
  parameter int STEP_CYCLES = `SOS_STEP_CYCLES,
  // Cycles of the cycle-complete pulse
  parameter int PULSE_CYCLES = `SOS_PULSE_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic running,
  input wire logic out_freq_zero,
  input wire logic ovl_est_valid,
  input wire logic [15:0] ovl_tenths_to_trip,
  input wire logic [15:0] count_value,
  input wire logic [15:0] actual_length,
  input wire logic plc_cycle_done,
  input wire logic [15:0] acc_run_time,
  input wire logic [15:0] cur_run_time,
  input wire logic [15:0] power_on_time,
  input wire logic set_freq_above_upper,
  input wire logic set_freq_below_lower,
  input wire logic at_upper_limit,
  input wire logic at_lower_limit,
  input wire logic speed_ctrl_mode,
  input wire logic torque_at_limit,
  input wire logic stall_active,
  input wire logic circuits_stable,
  input wire logic fault_present,
  input wire logic ready_to_run,
  input wire logic [11:0] analog_input_one,
  input wire logic [11:0] analog_input_two,
  input wire logic undervoltage,
  input wire logic load_zero,
  input wire logic reverse_run,
  input wire logic [15:0] module_temp,
  input wire logic [15:0] motor_temp,
  output logic terminal_closed
);

  // Byte lane merge of a write into an old word
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Strictly greater compare of two 16-bit quantities
  function automatic logic gt16(input logic [15:0] a,
                                input logic [15:0] b);
    return a > b;
  endfunction

  // Register storage
  logic [31:0] ctrl_q, ctrl_d; // Function, polarity, timing enable
  logic [15:0] delay_q, delay_d; // Output delay in tenths
  logic [15:0] cnt_set_q, cnt_set_d; // Set count threshold
  logic [15:0] cnt_des_q, cnt_des_d; // Designated count threshold
  logic [15:0] len_q, len_d; // Target length
  logic [15:0] acc_run_q, acc_run_d; // Accumulated run time threshold
  logic [15:0] cur_run_q, cur_run_d; // Current run time threshold
  logic [15:0] pwr_on_q, pwr_on_d; // Power-on time threshold
  logic [15:0] timing_q, timing_d; // Timing function run time
  logic [31:0] ai_win_q, ai_win_d; // Upper in high half, lower in low
  logic [15:0] mod_t_q, mod_t_d; // Module temperature threshold
  logic [15:0] mot_t_q, mot_t_d; // Motor overheat threshold
  logic comm_q, comm_d; // Communication commanded state
  logic [31:0] prdata_q, prdata_d; // Read data captured in setup

  // Bus decode
  wire setup_ph = psel & ~penable;
  wire wr_en = psel & penable & pwrite;
  wire hit_ctrl = paddr == `SOS_OFS_CTRL;
  wire hit_delay = paddr == `SOS_OFS_DELAY;
  wire hit_cset = paddr == `SOS_OFS_CNT_SET;
  wire hit_cdes = paddr == `SOS_OFS_CNT_DES;
  wire hit_len = paddr == `SOS_OFS_LEN;
  wire hit_acc = paddr == `SOS_OFS_ACC_RUN;
  wire hit_cur = paddr == `SOS_OFS_CUR_RUN;
  wire hit_pwr = paddr == `SOS_OFS_PWR_ON;
  wire hit_tim = paddr == `SOS_OFS_TIMING;
  wire hit_ai = paddr == `SOS_OFS_AI_WIN;
  wire hit_mod = paddr == `SOS_OFS_MOD_TEMP;
  wire hit_mot = paddr == `SOS_OFS_MOT_TEMP;
  wire hit_comm = paddr == `SOS_OFS_COMM;
  wire hit_stat = paddr == `SOS_OFS_STATUS;
  wire hit_any = hit_ctrl | hit_delay | hit_cset | hit_cdes | hit_len |
                 hit_acc | hit_cur | hit_pwr | hit_tim | hit_ai |
                 hit_mod | hit_mot | hit_comm | hit_stat;

  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_any;
  assign prdata = prdata_q;

  // Fields of the control word and of the window register
  wire [5:0] func_code = ctrl_q[`SOS_CTRL_FUNC_MSB:`SOS_CTRL_FUNC_LSB];
  wire polarity = ctrl_q[`SOS_CTRL_POL_BIT];
  wire timer_en = ctrl_q[`SOS_CTRL_TIMER_EN_BIT];
  wire [11:0] ai_upper = ai_win_q[27:16];
  wire [11:0] ai_lower = ai_win_q[11:0];

  // Merged write word for the delay register, clamped to one hour
  wire [31:0] delay_wr = wmerge({16'h0000, delay_q}, pwdata, pstrb);
  wire delay_over = gt16(delay_wr[15:0], `SOS_DELAY_MAX_TENTHS);

  // Status view
  logic raw_q; // Selected condition, registered
  logic delayed_q; // Condition after the output delay
  logic pulse_on; // Cycle-complete pulse active
  sos_dly_state_t dly_st_q, dly_st_d;
  wire [31:0] status_word = {27'h000_0000, dly_st_q, pulse_on,
                             delayed_q, raw_q, terminal_closed};

  // Write next-state for all software registers
  always_comb begin
    ctrl_d = ctrl_q;
    delay_d = delay_q;
    cnt_set_d = cnt_set_q;
    cnt_des_d = cnt_des_q;
    len_d = len_q;
    acc_run_d = acc_run_q;
    cur_run_d = cur_run_q;
    pwr_on_d = pwr_on_q;
    timing_d = timing_q;
    ai_win_d = ai_win_q;
    mod_t_d = mod_t_q;
    mot_t_d = mot_t_q;
    comm_d = comm_q;
    if (wr_en) begin
      // Only defined control bits are kept
      if (hit_ctrl) begin
        ctrl_d = wmerge(ctrl_q, pwdata, pstrb) & 32'h0000_033F;
      end
      if (hit_delay) begin
        delay_d = delay_over ? `SOS_DELAY_MAX_TENTHS : delay_wr[15:0];
      end
      if (hit_cset) begin
        cnt_set_d = 16'(wmerge({16'h0000, cnt_set_q}, pwdata, pstrb));
      end
      if (hit_cdes) begin
        cnt_des_d = 16'(wmerge({16'h0000, cnt_des_q}, pwdata, pstrb));
      end
      if (hit_len) begin
        len_d = 16'(wmerge({16'h0000, len_q}, pwdata, pstrb));
      end
      if (hit_acc) begin
        acc_run_d = 16'(wmerge({16'h0000, acc_run_q}, pwdata, pstrb));
      end
      if (hit_cur) begin
        cur_run_d = 16'(wmerge({16'h0000, cur_run_q}, pwdata, pstrb));
      end
      if (hit_pwr) begin
        pwr_on_d = 16'(wmerge({16'h0000, pwr_on_q}, pwdata, pstrb));
      end
      if (hit_tim) begin
        timing_d = 16'(wmerge({16'h0000, timing_q}, pwdata, pstrb));
      end
      // Window bounds sit in the low twelve bits of each half
      if (hit_ai) begin
        ai_win_d = wmerge(ai_win_q, pwdata, pstrb) & 32'h0FFF_0FFF;
      end
      if (hit_mod) begin
        mod_t_d = 16'(wmerge({16'h0000, mod_t_q}, pwdata, pstrb));
      end
      if (hit_mot) begin
        mot_t_d = 16'(wmerge({16'h0000, mot_t_q}, pwdata, pstrb));
      end
      if (hit_comm && pstrb[0]) begin
        comm_d = pwdata[0];
      end
    end
  end

  // Read mux, captured in the setup cycle so data comes from a flop
  always_comb begin
    prdata_d = prdata_q;
    if (setup_ph && !pwrite) begin
      case (1'b1)
        hit_ctrl: prdata_d = ctrl_q;
        hit_delay: prdata_d = {16'h0000, delay_q};
        hit_cset: prdata_d = {16'h0000, cnt_set_q};
        hit_cdes: prdata_d = {16'h0000, cnt_des_q};
        hit_len: prdata_d = {16'h0000, len_q};
        hit_acc: prdata_d = {16'h0000, acc_run_q};
        hit_cur: prdata_d = {16'h0000, cur_run_q};
        hit_pwr: prdata_d = {16'h0000, pwr_on_q};
        hit_tim: prdata_d = {16'h0000, timing_q};
        hit_ai: prdata_d = ai_win_q;
        hit_mod: prdata_d = {16'h0000, mod_t_q};
        hit_mot: prdata_d = {16'h0000, mot_t_q};
        hit_comm: prdata_d = {31'h0000_0000, comm_q};
        hit_stat: prdata_d = status_word;
        default: prdata_d = 32'h0000_0000;
      endcase
    end
  end

  // Register bank
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q <= `SOS_RST_CTRL;
      delay_q <= `SOS_RST_DELAY;
      cnt_set_q <= `SOS_RST_THRESH;
      cnt_des_q <= `SOS_RST_THRESH;
      len_q <= `SOS_RST_THRESH;
      acc_run_q <= `SOS_RST_THRESH;
      cur_run_q <= `SOS_RST_THRESH;
      pwr_on_q <= `SOS_RST_THRESH;
      timing_q <= `SOS_RST_THRESH;
      ai_win_q <= `SOS_RST_AI_WIN;
      mod_t_q <= `SOS_RST_THRESH;
      mot_t_q <= `SOS_RST_THRESH;
      comm_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      ctrl_q <= ctrl_d;
      delay_q <= delay_d;
      cnt_set_q <= cnt_set_d;
      cnt_des_q <= cnt_des_d;
      len_q <= len_d;
      acc_run_q <= acc_run_d;
      cur_run_q <= cur_run_d;
      pwr_on_q <= pwr_on_d;
      timing_q <= timing_d;
      ai_win_q <= ai_win_d;
      mod_t_q <= mod_t_d;
      mot_t_q <= mot_t_d;
      comm_q <= comm_d;
      prdata_q <= prdata_d;
    end
  end

  // Cycle-complete pulse stretcher; a new cycle retriggers the width
  logic [24:0] pulse_cnt_q;
  assign pulse_on = pulse_cnt_q != 25'h000_0000;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pulse_cnt_q <= 25'h000_0000;
    end else if (plc_cycle_done) begin
      pulse_cnt_q <= 25'(PULSE_CYCLES);
    end else if (pulse_on) begin
      pulse_cnt_q <= pulse_cnt_q - 25'h000_0001;
    end
  end

  // Per-code condition terms
  // ten second warning
  wire c_ovl = ovl_est_valid &
               !gt16(ovl_tenths_to_trip, `SOS_PREWARN_TENTHS);
  wire c_cset = count_value == cnt_set_q;
  wire c_cdes = count_value == cnt_des_q;
  wire c_len = gt16(actual_length, len_q);
  wire c_acc = gt16(acc_run_time, acc_run_q);
  wire c_cur = gt16(cur_run_time, cur_run_q);
  wire c_flim = (set_freq_above_upper & at_upper_limit) |
                (set_freq_below_lower & at_lower_limit);
  wire c_tlim = speed_ctrl_mode & torque_at_limit & stall_active;
  wire c_ready = circuits_stable & ~fault_present & ready_to_run;
  wire c_ai_gt = analog_input_one > analog_input_two;
  wire c_upper = running & at_upper_limit;
  // lower limit, off or on at stop
  wire c_lower = running & at_lower_limit;
  wire c_lower2 = ~running | at_lower_limit;
  wire c_zero2 = ~running | out_freq_zero;
  wire c_pwr = gt16(power_on_time, pwr_on_q);
  wire c_tim = timer_en & !gt16(timing_q, cur_run_time);
  wire c_ai_win = (analog_input_one > ai_upper) |
                  (analog_input_one < ai_lower);
  wire c_rev = running & reverse_run;
  wire c_mod = !gt16(mod_t_q, module_temp);
  wire c_alarm = running & fault_present;
  wire c_mot = !gt16(mot_t_q, motor_temp);

  // Function selection
  logic cond;
  always_comb begin
    case (sos_func_t'(func_code))
      SOS_F_NONE: cond = 1'b0;
      SOS_F_RUN: cond = running;
      SOS_F_OVL_WARN: cond = c_ovl;
      SOS_F_CNT_SET: cond = c_cset;
      SOS_F_CNT_DES: cond = c_cdes;
      SOS_F_LEN: cond = c_len;
      SOS_F_PLC: cond = pulse_on;
      SOS_F_ACC_RUN: cond = c_acc;
      SOS_F_FLIM: cond = c_flim;
      SOS_F_TLIM: cond = c_tlim;
      SOS_F_READY: cond = c_ready;
      SOS_F_AI_GT: cond = c_ai_gt;
      SOS_F_UPPER: cond = c_upper;
      SOS_F_LOWER: cond = c_lower;
      SOS_F_UVOLT: cond = undervoltage;
      SOS_F_COMM: cond = comm_q;
      SOS_F_ZERO2: cond = c_zero2;
      SOS_F_PWR_ON: cond = c_pwr;
      SOS_F_TIMING: cond = c_tim;
      SOS_F_AI_WIN: cond = c_ai_win;
      SOS_F_LOAD0: cond = load_zero;
      SOS_F_REV: cond = c_rev;
      SOS_F_MOD_T: cond = c_mod;
      SOS_F_LOWER2: cond = c_lower2;
      SOS_F_ALARM: cond = c_alarm;
      SOS_F_MOT_T: cond = c_mot;
      SOS_F_CUR_RUN: cond = c_cur;
      default: cond = 1'b0;
    endcase
  end

  // Output delay engine: the step divider restarts on every change, so
  // the delay is exact; a change that reverts before expiry is dropped
  logic [23:0] div_q; // Cycles within the current step
  logic [15:0] steps_q; // Steps already elapsed
  wire step_tick = div_q == 24'(STEP_CYCLES - 1);
  wire differ = raw_q != delayed_q;
  wire [15:0] steps_nx = steps_q + 16'h0001;
  wire expire = step_tick & !gt16(delay_q, steps_nx);

  // Next state of the engine
  always_comb begin
    dly_st_d = dly_st_q;
    case (dly_st_q)
      SOS_DLY_IDLE: begin
        if (differ && delay_q != 16'h0000) begin
          dly_st_d = SOS_DLY_WAIT;
        end
      end
      SOS_DLY_WAIT: begin
        if (!differ || expire) begin
          dly_st_d = SOS_DLY_IDLE;
        end
      end
      default: dly_st_d = SOS_DLY_IDLE;
    endcase
  end

  // Engine registers and terminal drive
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      raw_q <= 1'b0;
      delayed_q <= 1'b0;
      dly_st_q <= SOS_DLY_IDLE;
      div_q <= 24'h00_0000;
      steps_q <= 16'h0000;
      terminal_closed <= 1'b0;
    end else begin
      raw_q <= cond;
      dly_st_q <= dly_st_d;
      if (dly_st_q == SOS_DLY_WAIT && differ) begin
        div_q <= step_tick ? 24'h00_0000 : div_q + 24'h00_0001;
        steps_q <= step_tick ? steps_nx : steps_q;
      end else begin
        div_q <= 24'h00_0000;
        steps_q <= 16'h0000;
      end
      if (differ && (delay_q == 16'h0000 ||
          (dly_st_q == SOS_DLY_WAIT && expire))) begin
        delayed_q <= raw_q;
      end
      terminal_closed <= delayed_q ^ polarity;
    end
  end

endmodule // sos_top

/* verif/sos_top_props.sv */
// Checker bound to the selector top: bus answers and terminal levels
`include "sos_regs.svh"
module sos_chk
  import sos_pkg::*;
#(
  parameter int STEP_CYCLES = 4,
  parameter int PULSE_CYCLES = 10
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic running,
  input wire logic terminal_closed
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // Completed write and address classes
  wire logic wr_done = psel && penable && pready && pwrite;
  wire logic al = (paddr[1:0] == 2'b00);
  wire logic unmapped = al && (paddr > `SOS_OFS_STATUS);
  wire logic big = (pwdata[15:0] > `SOS_DELAY_MAX_TENTHS);
  wire logic [15:0] dly_d = big ? `SOS_DELAY_MAX_TENTHS : pwdata[15:0];
  // Shadows of what software wrote
  logic [5:0] func_q;
  logic pol_q, ten_q;
  logic [15:0] dly_q, quiet_q, hi_q;
  // Control shadow honours byte lanes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      {func_q, pol_q, ten_q} <= '0;
    end else if (wr_done && paddr == `SOS_OFS_CTRL) begin
      if (pstrb[0]) func_q <= pwdata[5:0];
      if (pstrb[1]) {ten_q, pol_q} <= pwdata[9:8];
    end
  end
  // Delay shadow, full low half only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dly_q <= 16'h0000;
    end else if (wr_done && paddr == `SOS_OFS_DELAY && &pstrb[1:0]) begin
      dly_q <= dly_d;
    end
  end
  // Cycles since a setup change; pending delays must drain first
  wire logic cfg_wr = wr_done && paddr <= `SOS_OFS_DELAY;
  always_ff @(posedge clk) begin
    if (sys_rst || cfg_wr) begin
      quiet_q <= 16'h0000;
    end else if (quiet_q != 16'hFFFF) begin
      quiet_q <= quiet_q + 16'h0001;
    end
  end
  // Length of the present high stretch
  always_ff @(posedge clk) begin
    if (sys_rst || !terminal_closed) begin
      hi_q <= 16'h0000;
    end else if (hi_q != 16'hFFFF) begin
      hi_q <= hi_q + 16'h0001;
    end
  end
  wire logic settled = 32'(quiet_q) > 32'(dly_q) * STEP_CYCLES + 32'd8;
  wire logic no_dly = settled && dly_q == 16'h0000;
  wire logic func_off = func_q == 6'd0 || func_q == 6'd21 ||
    func_q == 6'd22 || func_q > 6'd40;
  sequence rd_of(logic [7:0] a);
    psel && !penable && !pwrite && paddr == a ##1 psel && penable;
  endsequence
  sequence run_steady;
    (no_dly && func_q == 6'd1 && $stable(running)) [*5];
  endsequence

  chk_err_unmapped: assert property (
    psel && penable && unmapped |-> pslverr)
    else $error("no error on unmapped access");
  chk_rdata_zero: assert property (
    psel && penable && !pwrite && unmapped |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_rdata_hold: assert property (
    !(psel && !penable) |=> $stable(prdata))
    else $error("read data moved without a setup");
  chk_ctrl_readback: assert property (
    rd_of(`SOS_OFS_CTRL) |-> prdata == {22'h0, ten_q, pol_q, 2'b00, func_q})
    else $error("control readback wrong");
  chk_delay_clamp: assert property (
    rd_of(`SOS_OFS_DELAY) |-> prdata == {16'h0000, dly_q})
    else $error("delay readback wrong");
  chk_off_level: assert property (
    settled && func_off |-> terminal_closed == pol_q)
    else $error("inactive code drives terminal");
  chk_run_level: assert property (
    run_steady |-> terminal_closed == (running ^ pol_q))
    else $error("run code does not follow running");
  chk_pulse_width: assert property (
    $fell(terminal_closed) && func_q == 6'd11 && !pol_q && no_dly
    |-> hi_q == 16'(PULSE_CYCLES))
    else $error("cycle pulse width wrong");
endmodule // sos_chk

bind sos_top sos_chk #(.STEP_CYCLES(STEP_CYCLES),
  .PULSE_CYCLES(PULSE_CYCLES)) u_chk (.clk(clk), .sys_rst(sys_rst),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .running(running),
  .terminal_closed(terminal_closed));

/* verif/sos_load.sv */
// Relay load model hanging on the output terminal
module sos_load (
  input wire logic clk,
  input wire logic terminal_closed,
  output logic coil_on = 1'b0,
  output int unsigned switch_count = 0
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge clk) begin
    if (coil_on !== terminal_closed) switch_count <= switch_count + 1;
    coil_on <= terminal_closed;
  end
endmodule // sos_load

/* verif/testbench.sv */
// Self-checking bench for the status output selector
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STEP = 4;
  localparam int PULSE = 10;
  logic clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, terminal_closed, coil_on;
  logic [7:0] paddr = 8'h00;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rv;
  logic re, pol, ten, comm;
  // Flags: run, freq0, ovl valid, done, above, below, at upper,
  // at lower, speed, torque, stall, stable, fault, ready, uv, load0, rev
  logic [16:0] fl = '0;
  logic [15:0] ovl = '0, cnt = '0, len = '0, acc = '0, cur = '0;
  logic [15:0] pwr = '0, mtp = '0, ttp = '0;
  logic [11:0] ai1 = '0, ai2 = '0;
  logic [31:0] th [10];
  int n_errors = 0;
  int check_count = 0;
  int unsigned sw_cnt;
  // Clock at 125 MHz
  always #4 clk = ~clk;

  sos_top #(.STEP_CYCLES(STEP), .PULSE_CYCLES(PULSE)) i_sos_top (
    .clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .running(fl[0]), .out_freq_zero(fl[1]), .ovl_est_valid(fl[2]),
    .ovl_tenths_to_trip(ovl), .count_value(cnt), .actual_length(len),
    .plc_cycle_done(fl[3]), .acc_run_time(acc), .cur_run_time(cur),
    .power_on_time(pwr), .set_freq_above_upper(fl[4]),
    .set_freq_below_lower(fl[5]), .at_upper_limit(fl[6]),
    .at_lower_limit(fl[7]), .speed_ctrl_mode(fl[8]),
    .torque_at_limit(fl[9]), .stall_active(fl[10]),
    .circuits_stable(fl[11]), .fault_present(fl[12]),
    .ready_to_run(fl[13]), .analog_input_one(ai1),
    .analog_input_two(ai2), .undervoltage(fl[14]), .load_zero(fl[15]),
    .reverse_run(fl[16]), .module_temp(mtp), .motor_temp(ttp),
    .terminal_closed(terminal_closed));
  sos_load u_load (.clk(clk), .terminal_closed(terminal_closed),
    .coil_on(coil_on), .switch_count(sw_cnt));

  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One bus transfer; an idle cycle follows so strobes never collide
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    pstrb <= s;
    psel <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_errors++;
      close_out();
    end
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d, 4'hF);
  endtask

  task automatic rd(input logic [7:0] a, input string nm,
                    input logic [31:0] e, input logic er);
    apb(a, 1'b0, 32'h0000_0000, 4'h0);
    chk(nm, rv, e);
    chk(nm, {31'h0, re}, {31'h0, er});
  endtask

  // Edges until the terminal shows v, bounded
  task automatic wait_term(input logic v, output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (terminal_closed !== v && n < 300);
    if (n >= 300) begin
      n_errors++;
      close_out();
    end
  endtask

  // Expected condition of each code from the present stimulus
  function automatic logic exp_cond(input logic [5:0] c);
    case (c)
      6'd1: return fl[0];
      6'd7: return fl[2] && ovl <= 16'h0064;
      6'd8: return cnt == th[0][15:0];
      6'd9: return cnt == th[1][15:0];
      6'd10: return len > th[2][15:0];
      6'd12: return acc > th[3][15:0];
      6'd13: return (fl[4] && fl[6]) || (fl[5] && fl[7]);
      6'd14: return fl[8] && fl[9] && fl[10];
      6'd15: return fl[11] && !fl[12] && fl[13];
      6'd16: return ai1 > ai2;
      6'd17: return fl[0] && fl[6];
      6'd18: return fl[0] && fl[7];
      6'd19: return fl[14];
      6'd20: return comm;
      6'd23: return !fl[0] || fl[1];
      6'd24: return pwr > th[5][15:0];
      6'd30: return ten && cur >= th[6][15:0];
      6'd31: return ai1 > th[7][27:16] || ai1 < th[7][11:0];
      6'd32: return fl[15];
      6'd33: return fl[0] && fl[16];
      6'd35: return mtp >= th[8][15:0];
      6'd37: return !fl[0] || fl[7];
      6'd38: return fl[0] && fl[12];
      6'd39: return ttp >= th[9][15:0];
      6'd40: return cur > th[4][15:0];
      default: return 1'b0;
    endcase
  endfunction

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    close_out();
  end

  // Main sequence
  initial begin
    int n;
    int unsigned sw;
    logic [5:0] code;
    void'($urandom(32'hd1787481));
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(8'h00, "ctrl reset", 32'h0000_0000, 1'b0);
    rd(8'h34, "status reset", 32'h0000_0000, 1'b0);
    rd(8'h24, "window reset", 32'h0FFF_0000, 1'b0);
    rd(8'h3C, "unmapped read", 32'h0000_0000, 1'b1);
    wr(8'h04, 32'h0000_FFFF);
    rd(8'h04, "delay clamp", 32'h0000_8CA0, 1'b0);
    wr(8'h04, 32'h0000_0000);
    // Reserved bits dropped, second lane alone clears polarity
    wr(8'h00, 32'hFFFF_FFFF);
    apb(8'h00, 1'b1, 32'h0000_0000, 4'b0010);
    rd(8'h00, "ctrl lanes", 32'h0000_003F, 1'b0);
    // Every code first, then random codes; the pulse code apart
    for (int t = 0; t < 200; t++) begin
      code = (t < 64) ? 6'(t) : 6'($urandom_range(45));
      if (code == 6'd11) continue;
      {pol, ten, comm} = 3'($urandom);
      fl <= 17'($urandom);
      ovl <= 16'($urandom_range(104, 96));
      {cnt, len, acc, cur} <= {4{16'($urandom_range(7))}};
      pwr <= 16'($urandom_range(7));
      mtp <= 16'($urandom_range(7));
      ttp <= 16'($urandom_range(7));
      ai1 <= 12'($urandom_range(7));
      ai2 <= 12'($urandom_range(7));
      for (int i = 0; i < 10; i++) th[i] = 32'($urandom_range(7));
      th[7] = {4'h0, 12'($urandom_range(7, 5)), 16'($urandom_range(2))};
      for (int i = 0; i < 10; i++) wr(8'(8 + 4 * i), th[i]);
      wr(8'h30, {31'h0, comm});
      wr(8'h00, {22'h0, ten, pol, 2'b00, code});
      repeat (6) @(posedge clk);
      #1;
      chk("level", {31'h0, terminal_closed}, {31'h0, exp_cond(code) ^ pol});
      @(posedge clk);
    end
    // Single cycle-complete pulse, no retrigger
    fl <= '0;
    repeat (PULSE + 4) @(posedge clk);
    wr(8'h00, 32'h0000_000B);
    repeat (PULSE) @(posedge clk);
    sw = sw_cnt;
    fl[3] <= 1'b1;
    @(posedge clk);
    fl[3] <= 1'b0;
    wait_term(1'b1, n);
    wait_term(1'b0, n);
    chk("pulse width", 32'(n), 32'(PULSE));
    repeat (2) @(posedge clk);
    chk("load switches", 32'(sw_cnt - sw), 32'd2);
    // Output delay of three steps on both edges
    wr(8'h04, 32'h0000_0003);
    wr(8'h00, 32'h0000_0001);
    repeat (30) @(posedge clk);
    fl[0] <= 1'b1;
    wait_term(1'b1, n);
    chk("delay rise", 32'(n), 32'(3 * STEP + 3));
    @(posedge clk);
    fl[0] <= 1'b0;
    wait_term(1'b0, n);
    chk("delay fall", 32'(n), 32'(3 * STEP + 3));
    // A change shorter than the delay is lost
    @(posedge clk);
    fl[0] <= 1'b1;
    repeat (3) @(posedge clk);
    fl[0] <= 1'b0;
    n = 0;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      #1;
      if (terminal_closed !== 1'b0) n++;
    end
    chk("glitch dropped", 32'(n), 32'd0);
    close_out();
  end
endmodule // testbench
